/* rtl/event_irq_and_sample_check.sv */
// Event flags, open-drain interrupt request and input sample checker.
// Assumes sources, samples and serial pins are synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module event_irq_and_sample_check (
	input  wire logic                                ref_clk_i,           // 200 MHz clock
	input  wire logic                                sys_rst_i,           // Sync reset, high
	input  wire logic                                spi_cs_n_i,          // Serial select, low
	input  wire logic                                spi_sclk_i,          // Serial clock
	input  wire logic                                spi_sdi_i,           // Serial data in
	output logic                                     spi_sdo_o,           // Serial data out
	output logic                                     spi_sdo_oe_o,        // Serial out enable
	input  wire logic [irq_check_pkg::NUM_EXT-1:0]   event_src_i,         // External sources
	input  wire logic [irq_check_pkg::WORD_W-1:0]    sample_data_i,       // Input sample word
	input  wire logic                                sample_valid_i,      // One sample per pulse
	input  wire logic                                first_word_marker_i, // Marks first word
	output logic                                     irq_n_o,             // Request pin level
	output logic                                     irq_n_oe_o           // Request pin drive
);
	import irq_check_pkg::*;

	// ****************************************
	// Serial access
	// ****************************************
	logic              rd;
	logic              wr;
	logic [ADDR_W-1:0] addr;
	byte_t             wdata;
	byte_t             rdata;

	serial_reg_port u_port (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.cs_n_i    (spi_cs_n_i),
		.sclk_i    (spi_sclk_i),
		.sdi_i     (spi_sdi_i),
		.sdo_o     (spi_sdo_o),
		.sdo_oe_o  (spi_sdo_oe_o),
		.rd_o      (rd),
		.wr_o      (wr),
		.addr_o    (addr),
		.wdata_o   (wdata),
		.rdata_i   (rdata)
	);

	// ****************************************
	// Control registers
	// ****************************************
	logic                 soft_q;
	byte_t                en_lo_q;
	byte_t                en_hi_q;
	logic                 chk_en_q;
	logic                 auto_q;
	byte_t                cmp_q [NUM_CMP];
	logic                 wr_ctrl;
	logic                 wr_fl_hi;

	assign wr_ctrl  = wr && addr == ADDR_CHK_CTRL;
	assign wr_fl_hi = wr && addr == ADDR_FLAGS_HI;

	// Software reset level and interrupt enables
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			soft_q  <= 1'b0;
			en_lo_q <= REG_RESET;
			en_hi_q <= REG_RESET;
		end else if (wr) begin
			if (addr == ADDR_SOFT_RESET) begin
				soft_q <= wdata[SOFT_RST_BIT];
			end
			if (addr == ADDR_IRQ_EN_LO) begin
				en_lo_q <= wdata;
			end
			if (addr == ADDR_IRQ_EN_HI) begin
				en_hi_q <= wdata;
			end
		end
	end

	// Checker enable and auto clear mode
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_q) begin
			chk_en_q <= 1'b0;
			auto_q   <= 1'b0;
		end else if (wr_ctrl) begin
			chk_en_q <= wdata[CHK_EN_BIT];
			auto_q   <= wdata[AUTO_CLR_BIT];
		end
	end

	// Comparison values, low byte then high byte per word
	for (genvar g = 0; g < NUM_CMP; g++) begin : g_cmp
		always_ff @(posedge ref_clk_i) begin
			if (sys_rst_i) begin
				cmp_q[g] <= REG_RESET;
			end else if (wr && addr == ADDR_CMP_FIRST + ADDR_W'(g)) begin
				cmp_q[g] <= wdata;
			end
		end
	end

	// ****************************************
	// Sample alignment and compare
	// ****************************************
	logic                  mark_prev_q;
	logic [1:0]            word_idx_q;
	logic [1:0]            cur_idx;
	logic [WORD_W-1:0]     cmp_word;
	logic [WORD_W-1:0]     diff;
	logic                  cmp_go;
	logic                  err;

	// A fresh marker edge realigns to the first word, otherwise keep counting
	assign cur_idx  = (first_word_marker_i && !mark_prev_q) ? 2'h0 : word_idx_q;
	assign cmp_word = {cmp_q[{cur_idx, 1'b1}], cmp_q[{cur_idx, 1'b0}]};
	assign diff     = sample_data_i ^ cmp_word;
	assign cmp_go   = sample_valid_i && chk_en_q && !soft_q;
	assign err      = cmp_go && (|diff);

	// Word position within the four-word set
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_q) begin
			mark_prev_q <= 1'b0;
			word_idx_q  <= 2'h0;
		end else if (sample_valid_i) begin
			mark_prev_q <= first_word_marker_i;
			word_idx_q  <= cur_idx + 2'h1;
		end
	end

	// ****************************************
	// Checker status
	// ****************************************
	logic                  chk_err_q;
	logic                  fail_q;
	logic                  pass_q;
	logic [PASS_CNT_W-1:0] good_cnt_q;
	logic                  run_done;
	logic [WORD_W-1:0]     err_i_q;
	logic [WORD_W-1:0]     err_q_q;
	logic                  clr_chk;
	logic                  clr_fail;
	logic                  clr_pass;

	// Clean comparisons in a row, saturating at the run length
	assign run_done = cmp_go && !err && auto_q && good_cnt_q == PASS_RUN - 1'b1;

	// Clear through control write or through the matching flag bit
	assign clr_chk  = (wr_ctrl && wdata[CHK_ERR_BIT]) || (wr_fl_hi && wdata[FLAG_CHK - 8]);
	assign clr_fail = (wr_ctrl && wdata[CMP_FAIL_BIT]) || (wr_fl_hi && wdata[FLAG_FAIL - 8]);
	assign clr_pass = (wr_ctrl && wdata[CMP_PASS_BIT]) || (wr_fl_hi && wdata[FLAG_PASS - 8]);

	// Count of consecutive clean comparisons
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_q) begin
			good_cnt_q <= '0;
		end else if (cmp_go) begin
			if (err) begin
				good_cnt_q <= '0;
			end else if (good_cnt_q != PASS_RUN) begin
				good_cnt_q <= good_cnt_q + 1'b1;
			end
		end
	end

	// Sticky sample error bit, set wins over clear
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_q) begin
			chk_err_q <= 1'b0;
		end else if (err) begin
			chk_err_q <= 1'b1;
		end else if (clr_chk) begin
			chk_err_q <= 1'b0;
		end
	end

	// Fail and pass only live in auto clear mode
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_q || !auto_q) begin
			fail_q <= 1'b0;
			pass_q <= 1'b0;
		end else begin
			if (err) begin
				fail_q <= 1'b1;
			end else if (run_done || clr_fail) begin
				fail_q <= 1'b0;
			end
			if (cmp_go) begin
				pass_q <= !err;
			end else if (clr_pass) begin
				pass_q <= 1'b0;
			end
		end
	end

	// Per-bit error accumulation, I and Q words apart; a new error beats a clear
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i || soft_q || run_done || (clr_chk && !err)) begin
			err_i_q <= '0;
			err_q_q <= '0;
		end else if (err) begin
			if (cur_idx[0]) begin
				err_q_q <= err_q_q | diff;
			end else begin
				err_i_q <= err_i_q | diff;
			end
		end
	end

	// ****************************************
	// Event flags and request pin
	// ****************************************
	logic [NUM_FLAGS-1:0] src;
	logic [NUM_FLAGS-1:0] clr;
	logic [NUM_FLAGS-1:0] flags;
	logic                 irq_any;

	// Checker conditions share the high flag register
	assign src = {event_src_i[NUM_EXT-1:FLAG_PASS], chk_err_q, fail_q, pass_q,
		event_src_i[FLAG_PASS-1:0]};
	assign clr = {(wr_fl_hi ? wdata : REG_RESET),
		(wr && addr == ADDR_FLAGS_LO) ? wdata : REG_RESET};

	event_flag_bank u_flags (
		.ref_clk_i  (ref_clk_i),
		.sys_rst_i  (sys_rst_i),
		.soft_rst_i (soft_q),
		.src_i      (src),
		.en_i       ({en_hi_q, en_lo_q}),
		.clr_i      (clr),
		.flag_o     (flags),
		.irq_any_o  (irq_any)
	);

	// Open drain: only ever pull low, release otherwise
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			irq_n_o    <= 1'b0;
			irq_n_oe_o <= 1'b0;
		end else begin
			irq_n_o    <= 1'b0;
			irq_n_oe_o <= irq_any;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rdata = REG_RESET;
		if (addr >= ADDR_CMP_FIRST && addr <= ADDR_CMP_LAST) begin
			rdata = cmp_q[addr[2:0]];
		end else begin
			unique case (addr)
				ADDR_SOFT_RESET: rdata = {2'h0, soft_q, 5'h00};
				ADDR_IRQ_EN_LO:  rdata = en_lo_q;
				ADDR_IRQ_EN_HI:  rdata = en_hi_q;
				ADDR_FLAGS_LO:   rdata = flags[7:0];
				ADDR_FLAGS_HI:   rdata = flags[15:8];
				ADDR_CHK_CTRL:   rdata = {chk_en_q, auto_q, chk_err_q, 3'h0, fail_q, pass_q};
				ADDR_ERR_I_LO:   rdata = err_i_q[7:0];
				ADDR_ERR_I_HI:   rdata = err_i_q[15:8];
				ADDR_ERR_Q_LO:   rdata = err_q_q[7:0];
				ADDR_ERR_Q_HI:   rdata = err_q_q[15:8];
				default:         rdata = REG_RESET;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_mismatch;
		cmp_go && err;
	endsequence

	sequence s_clean_run_end;
		cmp_go && !err && auto_q && good_cnt_q == PASS_RUN - 1'b1;
	endsequence

	a_irq_tracks_latch: assert property (irq_any |=> irq_n_oe_o && !irq_n_o)
		else $error("request not driven for held latch");
	a_irq_released: assert property (!irq_any |=> !irq_n_oe_o)
		else $error("request driven with no latch");
	a_chk_err_sets: assert property (s_mismatch |=> chk_err_q)
		else $error("sample error bit missed a mismatch");
	a_chk_err_sticky: assert property (chk_err_q && !clr_chk && !soft_q |=> chk_err_q)
		else $error("sample error bit dropped on its own");
	a_fail_on_err: assert property (s_mismatch ##0 auto_q && !soft_q |=> fail_q)
		else $error("fail bit missed an error");
	a_pass_result: assert property (cmp_go && auto_q |=> pass_q == !$past(err))
		else $error("pass bit disagrees with last comparison");
	a_fail_auto_clr: assert property (s_clean_run_end |=> !fail_q && err_i_q == '0 && err_q_q == '0)
		else $error("auto clear did not clear after clean run");
	a_errbits_accum: assert property (err_i_q[0] && !run_done && !clr_chk && !soft_q |=> err_i_q[0])
		else $error("error bit lost without clear");
	a_soft_clears: assert property (soft_q ##1 soft_q |-> !irq_any)
		else $error("software reset left a latch");
	a_pass_off_manual: assert property (!auto_q |=> !pass_q && !fail_q)
		else $error("pass or fail active outside auto clear");

endmodule
`default_nettype wire

/* shared/irq_sed_pkg.sv */
// Constants shared by the event-flag, interrupt and sample-check logic.
// Assumes a 7-bit register address space reached through the serial control port.
package irq_check_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
	localparam logic [6:0] ADDR_IRQ_EN_LO  = 7'h04;
	localparam logic [6:0] ADDR_IRQ_EN_HI  = 7'h05;
	localparam logic [6:0] ADDR_FLAGS_LO   = 7'h06;
	localparam logic [6:0] ADDR_FLAGS_HI   = 7'h07;
	localparam logic [6:0] ADDR_CHK_CTRL   = 7'h67;
	localparam logic [6:0] ADDR_CMP_FIRST  = 7'h68;
	localparam logic [6:0] ADDR_CMP_LAST   = 7'h6F;
	localparam logic [6:0] ADDR_ERR_I_LO   = 7'h70;
	localparam logic [6:0] ADDR_ERR_I_HI   = 7'h71;
	localparam logic [6:0] ADDR_ERR_Q_LO   = 7'h72;
	localparam logic [6:0] ADDR_ERR_Q_HI   = 7'h73;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int SOFT_RST_BIT = 5;
	localparam int CHK_EN_BIT   = 7;
	localparam int AUTO_CLR_BIT = 6;
	localparam int CHK_ERR_BIT  = 5;
	localparam int CMP_FAIL_BIT = 1;
	localparam int CMP_PASS_BIT = 0;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Flag vector: low register is bits 7:0, high register bits 15:8
	localparam int NUM_FLAGS = 16;
	localparam int NUM_EXT   = 13;
	localparam int FLAG_PASS = 8;
	localparam int FLAG_FAIL = 9;
	localparam int FLAG_CHK  = 10;

	// ****************************************
	// Sample checker
	// ****************************************
	localparam int WORD_W     = 16;
	localparam int NUM_CMP    = 8;
	localparam int PASS_CNT_W = 4;
	localparam logic [PASS_CNT_W-1:0] PASS_RUN = 4'h8;

	// ****************************************
	// Serial port framing
	// ****************************************
	localparam int ADDR_W = 7;
	localparam int CNT_W  = 5;
	localparam logic [CNT_W-1:0] LAST_HDR_BIT = 5'h07;
	localparam logic [CNT_W-1:0] LAST_BIT     = 5'h0F;
	localparam logic [CNT_W-1:0] FIRST_DATA   = 5'h08;

	typedef logic [7:0] byte_t;

endpackage

/* rtl/event_flag_bank.sv */
// Per-flag edge latches and the combined interrupt term.
// Assumes sources are synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module event_flag_bank (
	input  wire logic                                ref_clk_i,  // System clock
	input  wire logic                                sys_rst_i,  // Sync reset, high
	input  wire logic                                soft_rst_i, // Software reset level
	input  wire logic [irq_check_pkg::NUM_FLAGS-1:0] src_i,      // Monitored sources
	input  wire logic [irq_check_pkg::NUM_FLAGS-1:0] en_i,       // Interrupt enables
	input  wire logic [irq_check_pkg::NUM_FLAGS-1:0] clr_i,      // Write-one clear pulses
	output logic      [irq_check_pkg::NUM_FLAGS-1:0] flag_o,     // Readable flag bits
	output logic                                     irq_any_o   // Some enabled latch held
);
	import irq_check_pkg::*;

	logic [NUM_FLAGS-1:0] src_q;
	logic [NUM_FLAGS-1:0] latch_q;

	// ****************************************
	// One latch per flag
	// ****************************************
	for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_flag
		// Previous source level for edge detection
		always_ff @(posedge ref_clk_i) begin
			if (sys_rst_i) begin
				src_q[g] <= 1'b0;
			end else begin
				src_q[g] <= src_i[g];
			end
		end

		// Enabled rising edge sets, write-one clears, set wins over clear
		always_ff @(posedge ref_clk_i) begin
			if (sys_rst_i || soft_rst_i) begin
				latch_q[g] <= 1'b0;
			end else if (en_i[g] && src_i[g] && !src_q[g]) begin
				latch_q[g] <= 1'b1;
			end else if (clr_i[g]) begin
				latch_q[g] <= 1'b0;
			end
		end

		// Enabled shows the latch, disabled shows the live source
		assign flag_o[g] = en_i[g] ? latch_q[g] : src_i[g];
	end

	// Only enabled latches reach the request line
	assign irq_any_o = |(latch_q & en_i);

endmodule
`default_nettype wire

/* rtl/serial_reg_port.sv */
// Serial control port: 16-bit frame, read flag, 7-bit address, 8-bit data.
// Assumes serial clock slower than a quarter of ref_clk_i, mode 0, MSB first.
`timescale 1ns/1ps
`default_nettype none
module serial_reg_port (
	input  wire logic                             ref_clk_i,  // System clock
	input  wire logic                             sys_rst_i,  // Sync reset, high
	input  wire logic                             cs_n_i,     // Chip select, low
	input  wire logic                             sclk_i,     // Serial clock
	input  wire logic                             sdi_i,      // Serial data in
	output logic                                  sdo_o,      // Serial data out
	output logic                                  sdo_oe_o,   // Serial out enable
	output logic                                  rd_o,       // Read pulse
	output logic                                  wr_o,       // Write pulse
	output logic      [irq_check_pkg::ADDR_W-1:0] addr_o,     // Register address
	output irq_check_pkg::byte_t                  wdata_o,    // Write data
	input  wire irq_check_pkg::byte_t             rdata_i     // Read data
);
	import irq_check_pkg::*;

	logic             sclk_q;
	logic [CNT_W-1:0] cnt_q;
	logic [14:0]      sh_q;
	logic             rw_q;
	logic             load_q;
	byte_t            tx_q;
	logic             rise;
	logic             fall;

	assign rise = sclk_i && !sclk_q;
	assign fall = !sclk_i && sclk_q;

	// Shift input bits and count them within a frame
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			sclk_q <= 1'b0;
			cnt_q  <= '0;
			sh_q   <= '0;
		end else begin
			sclk_q <= sclk_i;
			if (cs_n_i) begin
				cnt_q <= '0;
			end else if (rise) begin
				sh_q  <= {sh_q[13:0], sdi_i};
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// Header decode and access strobes
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			rw_q    <= 1'b0;
			rd_o    <= 1'b0;
			wr_o    <= 1'b0;
			load_q  <= 1'b0;
			addr_o  <= '0;
			wdata_o <= REG_RESET;
		end else begin
			rd_o   <= 1'b0;
			wr_o   <= 1'b0;
			load_q <= rd_o;
			if (!cs_n_i && rise && cnt_q == LAST_HDR_BIT) begin
				rw_q   <= sh_q[6];
				rd_o   <= sh_q[6];
				addr_o <= {sh_q[5:0], sdi_i};
			end
			if (!cs_n_i && rise && cnt_q == LAST_BIT && !rw_q) begin
				wr_o    <= 1'b1;
				wdata_o <= {sh_q[6:0], sdi_i};
			end
		end
	end

	// Read data leaves on falling edges of the data phase
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			tx_q     <= REG_RESET;
			sdo_o    <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else if (cs_n_i) begin
			sdo_oe_o <= 1'b0;
		end else if (load_q) begin
			tx_q <= rdata_i;
		end else if (fall && rw_q && cnt_q >= FIRST_DATA) begin
			sdo_o    <= tx_q[7];
			tx_q     <= {tx_q[6:0], 1'b0};
			sdo_oe_o <= 1'b1;
		end
	end

endmodule
`default_nettype wire

/* bench/spi_host_model.sv */
// Host model: serial control port master and the pulled-up request wire.
// Assumes the device samples the serial pins with ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic ref_clk_i,  // System clock
	output logic      cs_n_o,     // Serial select, low
	output logic      sclk_o,     // Serial clock, idle low
	output logic      sdi_o,      // Serial data to device
	input  wire logic sdo_i,      // Serial data from device
	input  wire logic sdo_oe_i,   // Device drives sdo
	input  wire logic irq_n_i,    // Request pin level
	input  wire logic irq_n_oe_i, // Request pin drive
	output logic      irq_line_o  // Resolved request wire
);
	logic sdo_last_q = 1'b0;
	logic sdo_line;

	// Pull-up wins unless the device pulls low, so other requesters can share it
	assign irq_line_o = irq_n_oe_i ? irq_n_i : 1'b1;
	// A released data line must not keep showing stale data
	assign sdo_line = sdo_oe_i ? sdo_i : ~sdo_last_q;
	always @(posedge ref_clk_i) begin
		sdo_last_q <= sdo_line;
	end

	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o  = 1'b0;
	end

	// One 16-bit frame, MSB first; read data taken at the last eight rising edges
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
		output logic [7:0] rdat);
		logic [15:0] f;
		f = {rd, a, wd};
		rdat = 8'h00;
		@(posedge ref_clk_i) cs_n_o <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			sdi_o <= f[15-i];
			repeat (5) @(posedge ref_clk_i);
			sclk_o <= 1'b1;
			if (i >= 8) rdat = {rdat[6:0], sdo_line};
			repeat (5) @(posedge ref_clk_i);
			sclk_o <= 1'b0;
		end
		repeat (5) @(posedge ref_clk_i);
		cs_n_o <= 1'b1; // Select must rise between frames
		repeat (4) @(posedge ref_clk_i);
	endtask
endmodule
`default_nettype wire

/* bench/event_irq_and_sample_check_tb_top.sv */
// Testbench: host model on the serial port, sources and samples from the bench.
// Assumes the design package and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module event_irq_and_sample_check_tb_top;
	import irq_check_pkg::*;
	typedef struct { string nm; logic [7:0] v; logic pin; } note_s;
	logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, valid = 1'b0, marker = 1'b0, res_stb = 1'b0;
	logic cs_n, sclk, sdi, sdo, sdo_oe, irq_n, irq_oe, irq_line;
	logic [12:0] src = '0, r;
	logic [15:0] data = '0, mask, mask2;
	logic [15:0] cmp [4];
	logic [7:0] res_val = '0, got;
	logic [6:0] rst_list [7] = '{7'h04, 7'h05, 7'h06, 7'h07, 7'h67, 7'h70, 7'h7F};
	int failures = 0, compares = 0, cycles = 0, seed = 82;
	note_s exp_q[$];
	note_s cur;

	event_irq_and_sample_check event_irq_and_sample_check_inst (.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_sdi_i(sdi),
		.spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .event_src_i(src), .sample_data_i(data),
		.sample_valid_i(valid), .first_word_marker_i(marker), .irq_n_o(irq_n),
		.irq_n_oe_o(irq_oe));
	spi_host_model spi_host_model_inst (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .sclk_o(sclk),
		.sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .irq_n_i(irq_n), .irq_n_oe_i(irq_oe),
		.irq_line_o(irq_line));

	initial forever #2.5 ref_clk_i = ~ref_clk_i;

	// Cut a hang short
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic compare_reg(string nm, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic compare_pin(string nm, logic e, logic g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask

	// Watcher: oldest note against each result that appears
	always @(posedge ref_clk_i) begin
		if (res_stb) begin
			cur = exp_q.pop_front();
			if (cur.pin) compare_pin(cur.nm, cur.v[0], res_val[0]);
			else compare_reg(cur.nm, cur.v, res_val);
		end
	end

	task automatic post(string nm, logic [7:0] e, logic p, logic [7:0] g);
		exp_q.push_back('{nm, e, p});
		res_val <= g;
		res_stb <= 1'b1;
		@(posedge ref_clk_i) res_stb <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	task automatic wr(logic [6:0] a, logic [7:0] d);
		spi_host_model_inst.xfer(1'b0, a, d, got);
	endtask

	task automatic rd(logic [6:0] a, logic [7:0] e);
		spi_host_model_inst.xfer(1'b1, a, 8'h00, got);
		post($sformatf("reg %h", a), e, 1'b0, got);
	endtask

	task automatic pin(logic e);
		repeat (4) @(posedge ref_clk_i);
		post("irq", {7'h00, e}, 1'b1, {7'h00, irq_line});
	endtask

	task automatic pulse(logic [12:0] v);
		@(posedge ref_clk_i) src <= v;
		@(posedge ref_clk_i) src <= '0;
	endtask

	// Words from the first one with the marker; word e gets mask m
	task automatic send_set(int e, logic [15:0] m, int n);
		for (int k = 0; k < n; k++) begin
			@(posedge ref_clk_i);
			valid <= 1'b1;
			marker <= (k == 0);
			data <= cmp[k] ^ ((k == e) ? m : 16'h0000);
			@(posedge ref_clk_i);
			valid <= 1'b0;
			marker <= 1'b0;
			data <= 16'($random(seed));
		end
	endtask

	initial begin
		for (int k = 0; k < 4; k++) cmp[k] = 16'($random(seed));
		mask = 16'($random(seed)) | 16'h0001;
		mask2 = {mask[7:0], mask[15:8]};
		r = 13'($random(seed));
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		for (int k = 0; k < 7; k++) rd(rst_list[k], REG_RESET);
		pin(1'b1);
		// Enables low: flags show live sources and never request
		@(posedge ref_clk_i) src <= r;
		rd(ADDR_FLAGS_LO, r[7:0]);
		rd(ADDR_FLAGS_HI, {r[12:8], 3'b000});
		pin(1'b1);
		// Sources low again, so the pulse below is a clean rising edge
		@(posedge ref_clk_i) src <= '0;
		wr(ADDR_IRQ_EN_LO, 8'hFF);
		pulse(13'h0021);
		pin(1'b0);
		rd(ADDR_FLAGS_LO, 8'h21);
		wr(ADDR_FLAGS_LO, 8'h01);
		pin(1'b0);
		rd(ADDR_FLAGS_LO, 8'h20);
		wr(ADDR_FLAGS_LO, 8'h20);
		pin(1'b1);
		// Service sequence with the source still high
		@(posedge ref_clk_i) src <= 13'h0004;
		pin(1'b0);
		wr(ADDR_IRQ_EN_LO, 8'h00);
		pin(1'b1);
		@(posedge ref_clk_i) src <= '0;
		rd(ADDR_FLAGS_LO, 8'h00);
		wr(ADDR_FLAGS_LO, 8'h04);
		wr(ADDR_IRQ_EN_LO, 8'hFF);
		pin(1'b1);
		pulse(13'h0010);
		pin(1'b0);
		wr(ADDR_SOFT_RESET, 8'h20);
		wr(ADDR_SOFT_RESET, 8'h00);
		pin(1'b1);
		rd(ADDR_FLAGS_LO, 8'h00);
		// Sample checker with auto clear
		for (int k = 0; k < 8; k++) wr(ADDR_CMP_FIRST + 7'(k), cmp[k/2][8*(k%2) +: 8]);
		wr(ADDR_IRQ_EN_HI, 8'h04);
		wr(ADDR_CHK_CTRL, 8'hC0);
		wr(ADDR_CHK_CTRL, 8'hE2);
		wr(ADDR_FLAGS_HI, 8'h07);
		send_set(4, 16'h0000, 4);
		rd(ADDR_CHK_CTRL, 8'hC1);
		pin(1'b1);
		send_set(1, mask, 4);
		rd(ADDR_CHK_CTRL, 8'hE3);
		rd(ADDR_ERR_Q_LO, mask[7:0]);
		rd(ADDR_ERR_Q_HI, mask[15:8]);
		pin(1'b0);
		send_set(2, mask2, 4);
		rd(ADDR_ERR_I_LO, mask2[7:0]);
		rd(ADDR_ERR_Q_LO, mask[7:0]);
		send_set(4, 16'h0000, 4);
		send_set(4, 16'h0000, 2);
		rd(ADDR_CHK_CTRL, 8'hE3);
		rd(ADDR_ERR_I_HI, mask2[15:8]);
		send_set(4, 16'h0000, 1);
		rd(ADDR_CHK_CTRL, 8'hE1);
		rd(ADDR_ERR_I_LO, 8'h00);
		rd(ADDR_ERR_Q_HI, 8'h00);
		wr(ADDR_FLAGS_HI, 8'h04);
		pin(1'b1);
		rd(ADDR_CHK_CTRL, 8'hC1);
		// Fail condition alone as a request source, cleared through its flag
		wr(ADDR_IRQ_EN_HI, 8'h02);
		send_set(3, mask, 4);
		pin(1'b0);
		wr(ADDR_FLAGS_HI, 8'h02);
		pin(1'b1);
		rd(ADDR_CHK_CTRL, 8'hE0);
		wr(ADDR_IRQ_EN_HI, 8'h04);
		// Without auto clear, pass and fail stay low
		wr(ADDR_CHK_CTRL, 8'hA2);
		send_set(0, mask, 4);
		rd(ADDR_CHK_CTRL, 8'hA0);
		rd(ADDR_ERR_I_HI, mask[15:8]);
		pin(1'b0);
		// Hardware reset in mid-run
		@(posedge ref_clk_i) sys_rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		pin(1'b1);
		rd(ADDR_CHK_CTRL, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
